/* core/otc_pkg.sv */
// Constants, period table and configuration checks for the oscillator training controller.
// Assumes a 40 MHz core clock derived from the oscillator that is being trained.
package otc_pkg;

  // Core clock rate and measurement interval.
  localparam int CLK_MHZ = 40;
  localparam int INTERVAL_US = 4000;
  localparam int NOM_CYCLES = INTERVAL_US * CLK_MHZ;

  // Allowed command-and-response period range.
  localparam int CRM_MIN_US = 500;
  localparam int CRM_MAX_US = 4000;

  // Delay from reset until training may start in PSI5 operation.
  localparam int RS_PM_US = 5000;
  localparam int RS_PM_CYCLES = RS_PM_US * CLK_MHZ;

  // Acceptance window, adjust threshold and trim step, in cycles and trim codes.
  localparam int WIN_CYCLES = 6400;
  localparam int ADJ_CYCLES = 160;
  localparam int STEP_CODES = 1;

  // Training error counter bounds, and the error, period, cycle and trim widths.
  localparam int ERR_W = 7;
  localparam logic [ERR_W-1:0] ERRCNT_MAX = 7'h7f;
  localparam logic [ERR_W-1:0] ERRCNT_MIN = 7'h00;
  localparam int PER_W = 4;
  localparam int CNT_W = 18;
  localparam int TRIM_W = 8;

  // Operating modes on the mode input.
  localparam logic [1:0] MODE_PSI5 = 2'h0;
  localparam logic [1:0] MODE_SPI = 2'h1;
  localparam logic [1:0] MODE_I2C = 2'h2;

  // Reference event decode.
  localparam logic [2:0] SOURCE_ID_ZERO = 3'h0;
  localparam logic [7:0] SENSOR_DATA_LOW_ADDR = 8'h00;

  // Periodic period code to microseconds.
  function automatic int otc_period_us(input logic [2:0] code);
    case (code)
      3'h0: return 250;
      3'h1: return 500;
      3'h2: return 1000;
      3'h3: return 2000;
      3'h4: return 4000;
      3'h5: return 800;
      3'h6: return 1500;
      default: return 3000;
    endcase
  endfunction : otc_period_us

  // Command-and-response period is the periodic period times (code plus one).
  function automatic int otc_crm_us(input logic [2:0] pcode, input logic [1:0] ccode);
    return otc_period_us(pcode) * (int'(ccode) + 1);
  endfunction : otc_crm_us

  // True when the period settings cannot support a 4 ms measurement.
  function automatic logic otc_cfg_bad(input logic [2:0] pcode, input logic [1:0] ccode);
    int crm;
    int per;
    crm = otc_crm_us(pcode, ccode);
    per = otc_period_us(pcode);
    return (crm < CRM_MIN_US) || (crm > CRM_MAX_US) || ((INTERVAL_US % crm) != 0)
           || ((INTERVAL_US % per) != 0);
  endfunction : otc_cfg_bad

endpackage : otc_pkg

/* core/otc_meas_if.sv */
// Carrier between the training controller and its cycle counter.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface otc_meas_if;
  logic event_pulse;
  logic run;
  logic [otc_pkg::PER_W-1:0] periods_needed;
  logic done;
  logic [otc_pkg::CNT_W-1:0] count;
  modport ctrl (output event_pulse, output run, output periods_needed, input done, input count);
  modport meas (input event_pulse, input run, input periods_needed, output done, output count);
endinterface : otc_meas_if

/* core/otc_meas.sv */
// Counts core clock cycles across a programmed number of reference periods.
// Assumes reference events are one-cycle pulses synchronous to core_clk.
`timescale 1ns/1ps
module otc_meas (
  input wire logic core_clk,
  input wire logic rst_n,
  otc_meas_if.meas m
);
  localparam int CNT_W = otc_pkg::CNT_W;
  localparam int PER_W = otc_pkg::PER_W;
  localparam logic [CNT_W-1:0] CNT_ONE = 18'h00001;
  localparam logic [PER_W-1:0] PER_ONE = 4'h1;

  logic armed;
  logic [CNT_W-1:0] cyc;
  logic [PER_W-1:0] per;
  logic closing;

  // The interval closes on the event that completes the programmed number of periods.
  assign closing = armed && m.event_pulse && ((per + PER_ONE) == m.periods_needed);

  // Arming: an event while run is high starts an interval; dropping run discards it.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else if (!m.run) begin
      armed <= 1'b0;
    end else if (m.event_pulse) begin
      armed <= 1'b1;
    end
  end

  // Cycle and period counters; the closing event also opens the next interval.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc <= '0;
      per <= '0;
    end else if (m.event_pulse && (!armed || closing)) begin
      cyc <= CNT_ONE;
      per <= '0;
    end else if (armed) begin
      cyc <= (&cyc) ? cyc : cyc + CNT_ONE; // Saturates so a lost master cannot wrap it.
      per <= m.event_pulse ? per + PER_ONE : per;
    end
  end

  // Result register and its one-cycle strobe.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      m.done <= 1'b0;
      m.count <= '0;
    end else begin
      m.done <= closing && m.run;
      if (closing) begin
        m.count <= cyc;
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  discard_partial_a: assert property (!m.run |=> !armed ##1 !m.done)
    else $error("Partial interval kept after run dropped.");
  count_fresh_a: assert property (m.event_pulse && !armed && m.run |=> cyc == CNT_ONE)
    else $error("Interval did not start from a fresh count.");

endmodule : otc_meas

/* core/otc_ctrl.sv */
// Oscillator training controller: measures master reference events over 4 ms and trims.
// Assumes all inputs are synchronous to core_clk and event inputs are one-cycle pulses.
// Overview of operation
// - PSI5 with training on measures sync pulse spacing against the periodic period.
// - Number of master periods per 4 ms interval is derived from the period.
// - Oscillator cycles are counted across that many master periods.
// - Trim changes only when the count lies inside the acceptance window.
// - Count above nominal plus threshold lowers the frequency target one step.
// - Count below nominal minus threshold raises the frequency target one step.
// - In PSI5 a trim change waits for the end of command blocking time.
// - PSI5 training ignores sync pulses in init phase one, starts after delay.
// - SPI reference events are sensor data requests to source identifier zero.
// - I2C reference events are reads of the low sensor data register.
// - Training enabled but impossible sets the training error flag.
// - Error counter counts up out of window and down inside it.
// - Error counter saturates at 127 and at 0.
// - Error flag sets once the counter reaches the configured threshold.
// - Error flag sets when command-and-response period lies outside 500 us to 4 ms.
// - Error flag sets when that period does not divide 4 ms exactly.
// - Disabling training keeps the last trim, or reverts it when the revert bit is set.
`timescale 1ns/1ps
module otc_ctrl #(
  parameter int NOM_CYC = otc_pkg::NOM_CYCLES,
  parameter int RS_PM_CYC = otc_pkg::RS_PM_CYCLES,
  parameter int WIN_CYC = otc_pkg::WIN_CYCLES,
  parameter int ADJ_CYC = otc_pkg::ADJ_CYCLES,
  parameter int STEP = otc_pkg::STEP_CODES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] mode,
  input wire logic training_enable_bit,
  input wire logic training_revert_bit,
  input wire logic [2:0] periodic_period_field,
  input wire logic [1:0] cmd_resp_period_field,
  input wire logic [otc_pkg::ERR_W-1:0] training_error_threshold,
  input wire logic init_phase_one,
  input wire logic sync_pulse,
  input wire logic spi_cmd_valid,
  input wire logic spi_sensor_req,
  input wire logic [2:0] spi_source_id,
  input wire logic i2c_read_valid,
  input wire logic [7:0] i2c_reg_addr,
  input wire logic cmd_block_end,
  output logic signed [otc_pkg::TRIM_W-1:0] freq_target,
  output logic training_error_flag,
  output logic training_active,
  output logic sync_ignore,
  output logic [otc_pkg::ERR_W-1:0] error_count,
  output logic [otc_pkg::CNT_W-1:0] last_count
);
  localparam int CNT_W = otc_pkg::CNT_W;
  localparam int TRIM_W = otc_pkg::TRIM_W;
  localparam int ERR_W = otc_pkg::ERR_W;
  localparam int PER_W = otc_pkg::PER_W;
  localparam int DLY_W = $clog2(RS_PM_CYC + 1);
  localparam logic signed [CNT_W:0] NOM_S = (CNT_W + 1)'(NOM_CYC);
  localparam logic signed [CNT_W:0] WIN_S = (CNT_W + 1)'(WIN_CYC);
  localparam logic signed [CNT_W:0] ADJ_S = (CNT_W + 1)'(ADJ_CYC);
  localparam logic signed [TRIM_W-1:0] STEP_S = TRIM_W'(STEP);
  localparam logic signed [TRIM_W-1:0] TRIM_MAX = {1'b0, {(TRIM_W - 1){1'b1}}};
  localparam logic signed [TRIM_W-1:0] TRIM_MIN = {1'b1, {(TRIM_W - 1){1'b0}}};
  localparam logic signed [TRIM_W-1:0] TRIM_UNTRAINED = '0;
  localparam logic [DLY_W-1:0] DLY_END = DLY_W'(RS_PM_CYC);
  localparam logic [DLY_W-1:0] DLY_ONE = DLY_W'(1);
  localparam logic [ERR_W-1:0] ERR_ONE = ERR_W'(1);

  // Refuse settings that the counters cannot hold, at elaboration.
  if (NOM_CYC + WIN_CYC >= (1 << CNT_W) || ADJ_CYC > WIN_CYC || STEP < 1
      || STEP > 2 ** (TRIM_W - 2) || RS_PM_CYC < 1) begin : g_bad_params
    $error("otc_ctrl: parameter values out of range.");
  end

  typedef enum logic [1:0] {OTC_ST_DELAY, OTC_ST_IDLE, OTC_ST_TRAIN} otc_state_t;

  otc_state_t state;
  logic [DLY_W-1:0] dly;
  logic cfg_bad;
  logic ref_event;
  logic signed [CNT_W:0] diff;
  logic in_win;
  logic go_down;
  logic go_up;
  logic pend_down;
  logic pend_up;
  logic apply_down;
  logic apply_up;
  logic psi5;

  otc_meas_if m ();

  otc_meas u_meas (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .m(m)
  );

  assign psi5 = (mode == otc_pkg::MODE_PSI5);
  assign cfg_bad = otc_pkg::otc_cfg_bad(periodic_period_field, cmd_resp_period_field);

  // Reference event selection per mode.
  always_comb begin
    case (mode)
      otc_pkg::MODE_PSI5: ref_event = sync_pulse && !init_phase_one;
      otc_pkg::MODE_SPI: ref_event = spi_cmd_valid && spi_sensor_req
                                     && (spi_source_id == otc_pkg::SOURCE_ID_ZERO);
      otc_pkg::MODE_I2C: ref_event = i2c_read_valid
                                     && (i2c_reg_addr == otc_pkg::SENSOR_DATA_LOW_ADDR);
      default: ref_event = 1'b0;
    endcase
  end

  // Sync pulses are not answered during phase one while PSI5 training is on.
  assign sync_ignore = psi5 && training_enable_bit && init_phase_one;

  // Measurement only runs in training with a usable configuration; dropping it discards.
  assign m.run = (state == OTC_ST_TRAIN) && training_enable_bit && !cfg_bad;
  assign m.event_pulse = ref_event && (state == OTC_ST_TRAIN);
  assign m.periods_needed = PER_W'(otc_pkg::INTERVAL_US
                                   / otc_pkg::otc_period_us(periodic_period_field));
  assign training_active = m.run;

  // Reset-to-program delay counter; it only runs until it expires.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dly <= '0;
    end else if (dly != DLY_END) begin
      dly <= dly + DLY_ONE;
    end
  end

  // Training state: wait out the delay, then follow the enable bit.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= OTC_ST_DELAY;
    end else begin
      case (state)
        OTC_ST_DELAY: state <= (dly == DLY_END) ? OTC_ST_IDLE : OTC_ST_DELAY;
        OTC_ST_IDLE: state <= training_enable_bit ? OTC_ST_TRAIN : OTC_ST_IDLE;
        OTC_ST_TRAIN: state <= training_enable_bit ? OTC_ST_TRAIN : OTC_ST_IDLE;
        default: state <= OTC_ST_IDLE;
      endcase
    end
  end

  // Window comparison of the finished count against nominal.
  assign diff = $signed({1'b0, m.count}) - NOM_S;
  assign in_win = (diff <= WIN_S) && (diff >= -WIN_S);
  assign go_down = m.done && in_win && (diff > ADJ_S);
  assign go_up = m.done && in_win && (diff < -ADJ_S);

  // PSI5 holds the decision until command blocking ends; other modes apply at once.
  assign apply_down = psi5 ? (cmd_block_end && pend_down) : go_down;
  assign apply_up = psi5 ? (cmd_block_end && pend_up) : go_up;

  // Pending decision for PSI5; a new result replaces an unapplied one.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_down <= 1'b0;
      pend_up <= 1'b0;
    end else if (!training_enable_bit || !psi5) begin
      pend_down <= 1'b0;
      pend_up <= 1'b0;
    end else if (m.done) begin
      pend_down <= go_down;
      pend_up <= go_up;
    end else if (cmd_block_end) begin
      pend_down <= 1'b0;
      pend_up <= 1'b0;
    end
  end

  // Frequency target: saturating steps, or hold or revert once training is off.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_target <= TRIM_UNTRAINED;
    end else if (!training_enable_bit) begin
      if (training_revert_bit) begin
        freq_target <= TRIM_UNTRAINED;
      end
    end else if (apply_down) begin
      freq_target <= (freq_target < TRIM_MIN + STEP_S) ? TRIM_MIN
                     : freq_target - STEP_S;
    end else if (apply_up) begin
      freq_target <= (freq_target > TRIM_MAX - STEP_S) ? TRIM_MAX
                     : freq_target + STEP_S;
    end
  end

  // Up/down error filter; it freezes while training is off.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      error_count <= otc_pkg::ERRCNT_MIN;
    end else if (m.done && !in_win) begin
      error_count <= (error_count == otc_pkg::ERRCNT_MAX) ? error_count
                     : error_count + ERR_ONE;
    end else if (m.done && in_win) begin
      error_count <= (error_count == otc_pkg::ERRCNT_MIN) ? error_count
                     : error_count - ERR_ONE;
    end
  end

  // Error flag follows the filter and the configuration check while enabled.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      training_error_flag <= 1'b0;
    end else begin
      training_error_flag <= training_enable_bit
                             && ((error_count >= training_error_threshold)
                                 || cfg_bad);
    end
  end

  // Last measured count is kept for software visibility.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_count <= '0;
    end else if (m.done) begin
      last_count <= m.count;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  lower_step_a: assert property (
    go_down && !psi5 && training_enable_bit && freq_target >= TRIM_MIN + STEP_S
    |=> freq_target == $past(freq_target) - STEP_S)
    else $error("Frequency target not lowered by one step.");
  raise_step_a: assert property (
    go_up && !psi5 && training_enable_bit && freq_target <= TRIM_MAX - STEP_S
    |=> freq_target == $past(freq_target) + STEP_S)
    else $error("Frequency target not raised by one step.");
  out_window_a: assert property (
    m.done && !in_win && !psi5 && training_enable_bit |=> $stable(freq_target))
    else $error("Trim changed on out-of-window count.");
  psi5_wait_a: assert property (
    psi5 && !cmd_block_end && training_enable_bit |=> $stable(freq_target))
    else $error("PSI5 trim changed outside command blocking end.");
  psi5_apply_a: assert property (
    psi5 && training_enable_bit && cmd_block_end && pend_up
    && freq_target <= TRIM_MAX - STEP_S
    |=> freq_target == $past(freq_target) + STEP_S)
    else $error("PSI5 pending raise not applied.");
  err_up_a: assert property (
    m.done && !in_win && error_count != otc_pkg::ERRCNT_MAX
    |=> error_count == $past(error_count) + ERR_ONE)
    else $error("Error counter did not count up.");
  err_sat_a: assert property (
    (m.done && in_win && error_count == otc_pkg::ERRCNT_MIN |=> error_count == otc_pkg::ERRCNT_MIN)
    and (m.done && !in_win && error_count == otc_pkg::ERRCNT_MAX
         |=> error_count == otc_pkg::ERRCNT_MAX))
    else $error("Error counter left its bounds.");
  err_flag_a: assert property (
    training_enable_bit && $rose(error_count >= training_error_threshold)
    && $stable(training_enable_bit) |=> training_error_flag)
    else $error("Error flag missed the threshold.");
  bad_cfg_a: assert property (
    training_enable_bit && cfg_bad |-> !training_active ##1 training_error_flag)
    else $error("Bad period setting not flagged.");
  sync_ignore_a: assert property (
    psi5 && init_phase_one && sync_pulse |-> !m.event_pulse ##1 !m.done)
    else $error("Sync pulse used during init phase one.");
  delay_gate_a: assert property (
    dly != DLY_END |-> !training_active)
    else $error("Training active before reset delay ended.");
  revert_a: assert property (
    !training_enable_bit && training_revert_bit |=> freq_target == TRIM_UNTRAINED)
    else $error("Trim not reverted while disabled.");
  hold_a: assert property (
    !training_enable_bit && !training_revert_bit |=> $stable(freq_target))
    else $error("Trim not held while disabled.");

  down_seen_c: cover property (apply_down);
  up_psi5_c: cover property (psi5 && apply_up);
  err_flag_c: cover property ($rose(training_error_flag) && !cfg_bad);
  revert_c: cover property ($fell(training_enable_bit) && training_revert_bit);

endmodule : otc_ctrl

/* bench/otc_master_model.sv */
// Behavioural bus master that issues periodic timing reference events.
// Assumes a free-running core_clk; every event is a pulse launched on a falling edge.
`timescale 1ns/1ps
module otc_master_model (
  input wire logic core_clk,
  input wire logic [1:0] mode,
  input wire logic req,
  input wire logic [7:0] gap,
  input wire logic [3:0] cnt,
  input wire logic bad,
  output logic busy,
  output logic sync_pulse,
  output logic spi_cmd_valid,
  output logic spi_sensor_req,
  output logic [2:0] spi_source_id,
  output logic i2c_read_valid,
  output logic [7:0] i2c_reg_addr
);
  int n;
  int cyc_now = 0;
  int last_at = -1000;

  // Cycle stamp on the rising edge, so the falling-edge driver always reads a settled value.
  always @(posedge core_clk) begin
    cyc_now <= cyc_now + 1;
  end

  // One event of the selected kind; bad events carry a wrong source or register.
  task automatic fire();
    sync_pulse = (mode == otc_pkg::MODE_PSI5);
    spi_cmd_valid = (mode == otc_pkg::MODE_SPI);
    i2c_read_valid = (mode == otc_pkg::MODE_I2C);
    spi_sensor_req = 1'b1;
    spi_source_id = bad ? 3'h3 : otc_pkg::SOURCE_ID_ZERO;
    i2c_reg_addr = bad ? 8'h01 : otc_pkg::SENSOR_DATA_LOW_ADDR;
    @(negedge core_clk);
    sync_pulse = 1'b0;
    spi_cmd_valid = 1'b0;
    i2c_read_valid = 1'b0;
    spi_sensor_req = 1'b0;
    // Qualifiers are inverted once released, so a stale value can never pass as valid.
    spi_source_id = ~spi_source_id;
    i2c_reg_addr = ~i2c_reg_addr;
  endtask : fire

  // A burst of cnt events spaced gap cycles apart, at the period the bench programmed.
  initial begin
    busy = 1'b0;
    sync_pulse = 1'b0;
    spi_cmd_valid = 1'b0;
    i2c_read_valid = 1'b0;
    spi_sensor_req = 1'b0;
    spi_source_id = 3'h5;
    i2c_reg_addr = 8'ha5;
    forever begin
      @(posedge core_clk);
      if (req === 1'b1) begin
        busy = 1'b1;
        @(negedge core_clk);
        for (n = 0; n < int'(cnt); n++) begin
          // The first event of a burst keeps the spacing too, as intervals run on across bursts.
          while (cyc_now - last_at < int'(gap)) @(negedge core_clk);
          last_at = cyc_now;
          fire();
        end
        busy = 1'b0;
      end
    end
  end
endmodule : otc_master_model

/* bench/otc_ctrl_tb.sv */
// Self-checking bench for the oscillator training controller.
// Assumes shortened counts: nominal 400 cycles, window 40, adjust 4, start delay 20.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module otc_ctrl_tb;
  logic core_clk, rst_n, en, rev, init1, cbe, req, bad, busy;
  logic [1:0] mode, ccode;
  logic [2:0] pcode, sid;
  logic [6:0] thr, ecnt;
  logic [7:0] gap, iaddr;
  logic [3:0] cnt;
  logic sync, scv, ssr, i2v, flag, act, sign;
  logic signed [7:0] ft;
  logic [17:0] lcnt;
  int err_total = 0;
  int tests_run = 0;
  logic [5:0] tab [5] = '{6'h16, 6'h01, 6'h2b, 6'h15, 6'h1d};

  otc_ctrl #(.NOM_CYC(400), .RS_PM_CYC(20), .WIN_CYC(40), .ADJ_CYC(4), .STEP(1)) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .mode(mode), .training_enable_bit(en),
    .training_revert_bit(rev), .periodic_period_field(pcode), .cmd_resp_period_field(ccode),
    .training_error_threshold(thr), .init_phase_one(init1), .sync_pulse(sync),
    .spi_cmd_valid(scv), .spi_sensor_req(ssr), .spi_source_id(sid), .i2c_read_valid(i2v),
    .i2c_reg_addr(iaddr), .cmd_block_end(cbe), .freq_target(ft), .training_error_flag(flag),
    .training_active(act), .sync_ignore(sign), .error_count(ecnt), .last_count(lcnt));

  otc_master_model i_master (
    .core_clk(core_clk), .mode(mode), .req(req), .gap(gap), .cnt(cnt), .bad(bad),
    .busy(busy), .sync_pulse(sync), .spi_cmd_valid(scv), .spi_sensor_req(ssr),
    .spi_source_id(sid), .i2c_read_valid(i2v), .i2c_reg_addr(iaddr));

  // Free-running 40 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  task automatic timeout();
    err_total++;
    tally_and_finish();
  endtask : timeout

  // Reset held for 8 cycles with a legal 1 ms period, training on.
  task automatic do_reset(input logic [1:0] m, input logic [6:0] t);
    @(negedge core_clk);
    rst_n = 1'b0;
    mode = m;
    thr = t;
    en = 1'b1;
    rev = 1'b0;
    pcode = 3'h2;
    ccode = 2'h0;
    tick(8);
    rst_n = 1'b1;
  endtask : do_reset

  // Bounded wait for the start delay to run out.
  task automatic wait_active();
    int i;
    for (i = 0; i < 100 && act !== 1'b1; i++) tick(1);
    if (act !== 1'b1) timeout();
  endtask : wait_active

  // One master burst, then enough settle time for count, trim and flag to land.
  task automatic burst(input logic [7:0] g, input logic [3:0] c, input logic b);
    int i;
    gap = g;
    cnt = c;
    bad = b;
    req = 1'b1;
    tick(1);
    req = 1'b0;
    for (i = 0; i < 4000 && busy === 1'b1; i++) tick(1);
    if (busy === 1'b1) timeout();
    tick(4);
  endtask : burst

  // Four 1 ms periods make one interval: fast, slow and nominal masters.
  task automatic t_spi();
    do_reset(otc_pkg::MODE_SPI, 7'h7f);
    wait_active();
    `CHK(ft, 8'h00)
    `CHK(lcnt, 18'h00000)
    burst(8'd90, 4'h5, 1'b0);
    `CHK(lcnt, 18'd360)
    `CHK(ft, 8'h01)
    `CHK(ecnt, 7'h00)
    burst(8'd110, 4'h4, 1'b0);
    `CHK(lcnt, 18'd440)
    `CHK(ft, 8'h00)
    burst(8'd100, 4'h4, 1'b0);
    `CHK(ft, 8'h00)
    burst(8'd90, 4'h4, 1'b1);
    `CHK(lcnt, 18'd400)
    // A partial interval cut by disabling must not leak into the next one.
    burst(8'd100, 4'h2, 1'b0);
    en = 1'b0;
    tick(2);
    en = 1'b1;
    wait_active();
    burst(8'd104, 4'h5, 1'b0);
    `CHK(lcnt, 18'd416)
    $display("spi test done");
  endtask : t_spi

  // Reads of the wrong register are refused; an out-of-window count only moves the filter.
  task automatic t_i2c();
    do_reset(otc_pkg::MODE_I2C, 7'h01);
    wait_active();
    burst(8'd90, 4'h3, 1'b1);
    burst(8'd120, 4'h5, 1'b0);
    `CHK(lcnt, 18'd480)
    `CHK(ft, 8'h00)
    `CHK(ecnt, 7'h01)
    `CHK(flag, 1'b1)
    burst(8'd100, 4'h4, 1'b0);
    `CHK(ecnt, 7'h00)
    `CHK(flag, 1'b0)
    $display("i2c test done");
  endtask : t_i2c

  // Sync pulses in phase one are ignored; the trim waits for blocking time to end.
  task automatic t_psi5();
    do_reset(otc_pkg::MODE_PSI5, 7'h7f);
    init1 = 1'b1;
    tick(10);
    `CHK(act, 1'b0)
    wait_active();
    `CHK(sign, 1'b1)
    burst(8'd90, 4'h5, 1'b0);
    `CHK(lcnt, 18'h00000)
    init1 = 1'b0;
    burst(8'd90, 4'h5, 1'b0);
    `CHK(lcnt, 18'd360)
    `CHK(sign, 1'b0)
    `CHK(ft, 8'h00)
    cbe = 1'b1;
    tick(1);
    cbe = 1'b0;
    tick(1);
    `CHK(ft, 8'h01)
    en = 1'b0;
    tick(3);
    `CHK(ft, 8'h01)
    rev = 1'b1;
    tick(2);
    `CHK(ft, 8'h00)
    $display("psi5 test done");
  endtask : t_psi5

  // Period settings: each entry holds periodic code, response code and expected flag.
  task automatic t_cfg();
    int i;
    do_reset(otc_pkg::MODE_SPI, 7'h7f);
    for (i = 0; i < 5; i++) begin
      {pcode, ccode} = tab[i][5:1];
      tick(3);
      `CHK(flag, tab[i][0])
    end
    $display("config test done");
  endtask : t_cfg

  // Every input is defined at time zero, then the scenarios run in turn.
  initial begin
    rst_n = 1'b0;
    en = 1'b0;
    rev = 1'b0;
    init1 = 1'b0;
    cbe = 1'b0;
    req = 1'b0;
    bad = 1'b0;
    mode = 2'h1;
    ccode = 2'h0;
    pcode = 3'h2;
    thr = 7'h7f;
    gap = 8'd100;
    cnt = 4'h4;
    t_spi();
    t_i2c();
    t_psi5();
    t_cfg();
    tally_and_finish();
  end
endmodule : otc_ctrl_tb
